// [rtl/hrs_return_stack.sv]
// hardware return-address stack with its stack space flag and status register view
`timescale 1ns/1ps
`include "hrs_map.svh"

// What this block does
// - The stack holds sixteen sixteen-bit program counter values.
// - The storage and its pointer are private: no port reads or writes the pointer or the array.
// - A call or an acknowledged interrupt pushes the current program counter.
// - A plain return, a return with literal or a return from interrupt pops the stack.
// - Push and pop never touch the pc high holding latch, which keeps its value.
// - The pointer wraps around sixteen positions and is zero after reset.
// - Reset sets the stack space flag to one.
// - The flag clears whenever the pointer reaches fifteen.
// - A push that wraps the pointer from fifteen to zero locks the flag clear until reset.
// - There is no separate underflow flag; underflow leaves the pointer at the top and the flag shows it.
// - A pop before any push after reset clears the flag so the stack looks full.
// - A push right after that early pop locks the flag clear until reset.
// - Pushes beyond sixteen overwrite the oldest entries in order.
// - Pushes and pops happen only as side effects of calls, returns and interrupt vectoring.
// - The flag reads as bit five of the status register at address 06h and writes do not change it.
// - Writes to the status register leave the flag and both power status bits unchanged.
module hrs_return_stack
    import hrs_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int PC_WIDTH = 16
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire hrs_req_type i_req,
    input wire hrs_dbus_type i_dbus,
    input wire logic i_latch_wr,
    input wire logic [7:0] i_latch_wdata,
    input wire logic i_timeout_n,
    input wire logic i_power_down_n,
    output hrs_resp_type o_pop,
    output logic o_stack_space_flag,
    output logic [7:0] o_cpu_status_register,
    output logic o_global_int_disable,
    output logic [7:0] o_pc_high_holding_latch
);

    localparam int AW = $clog2(DEPTH);

    ////////////////////////////////////////////////////////////////////////////////
    // request decoding

    function automatic logic op_is_push(input hrs_op_type op);
        op_is_push = (op == HRS_OP_CALL) || (op == HRS_OP_INT_ACK);
    endfunction

    function automatic logic op_is_pop(input hrs_op_type op);
        op_is_pop = (op == HRS_OP_RETURN) || (op == HRS_OP_RETURN_WITH_LITERAL) ||
                    (op == HRS_OP_RETURN_FROM_INTERRUPT);
    endfunction

    logic push;
    logic pop;

    // the sequencer never issues both; if it did, the push wins so no return address is lost
    assign push = op_is_push(i_req.op);
    assign pop = op_is_pop(i_req.op) && !push;

    ////////////////////////////////////////////////////////////////////////////////
    // pointer and storage

    logic [AW-1:0] ptr;
    logic [AW-1:0] next_ptr;
    logic [AW-1:0] top_idx;
    logic [PC_WIDTH-1:0] rd_data;

    // ptr names the next free slot; the newest entry sits one below it
    assign top_idx = ptr - AW'(1);

    always_comb begin
        next_ptr = ptr;
        if (push) begin
            next_ptr = ptr + AW'(1);
        end else if (pop) begin
            next_ptr = ptr - AW'(1);
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ptr <= AW'(`HRS_PTR_RESET);
        end else begin
            ptr <= next_ptr;
        end
    end

    // writing at the wrapped pointer overwrites the oldest entry once sixteen are held
    hrs_stack_mem #(
        .DEPTH(DEPTH),
        .WIDTH(PC_WIDTH),
        .AW(AW)
    ) u_mem (
        .i_clk(i_clk),
        .i_wr(push),
        .i_waddr(ptr),
        .i_wdata(i_req.pc),
        .i_raddr(top_idx),
        .o_rdata(rd_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // pop answer, registered so the sequencer sees a steady value

    hrs_resp_type pop_resp;
    hrs_resp_type next_pop_resp;

    always_comb begin
        next_pop_resp.valid = pop;
        next_pop_resp.pc = pop_resp.pc;
        if (pop) begin
            next_pop_resp.pc = rd_data;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pop_resp <= '0;
        end else begin
            pop_resp <= next_pop_resp;
        end
    end

    assign o_pop = pop_resp;

    ////////////////////////////////////////////////////////////////////////////////
    // stack space flag

    hrs_state_type state;
    hrs_state_type next_state;

    always_comb begin
        next_state = state;
        unique case (state)
            HRS_ST_LOCKED: begin
                next_state = HRS_ST_LOCKED;
            end
            HRS_ST_AVAILABLE, HRS_ST_FULL: begin
                if (push && (ptr == AW'(`HRS_PTR_TOP))) begin
                    // overflow, or a push right after an early pop, both wrap top to zero
                    next_state = HRS_ST_LOCKED;
                end else if (next_ptr == AW'(`HRS_PTR_TOP)) begin
                    // also covers the pop from zero before any push
                    next_state = HRS_ST_FULL;
                end else begin
                    next_state = HRS_ST_AVAILABLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= HRS_ST_AVAILABLE;
        end else begin
            state <= next_state;
        end
    end

    assign o_stack_space_flag = (state == HRS_ST_AVAILABLE);

    ////////////////////////////////////////////////////////////////////////////////
    // status register and pc high holding latch

    logic glint_disable;
    logic next_glint_disable;
    logic [7:0] pc_high_holding_latch;
    logic [7:0] next_pc_high_holding_latch;
    logic [7:0] status;
    logic [7:0] next_status;
    logic stat_hit;

    assign stat_hit = i_dbus.wr && (i_dbus.addr == `HRS_STAT_ADDR);

    always_comb begin
        next_glint_disable = glint_disable;
        // only the interrupt disable bit takes the write; flag and power bits ignore it
        if (stat_hit) begin
            next_glint_disable = i_dbus.wdata[`HRS_STAT_GLINT_BIT];
        end
        next_pc_high_holding_latch = pc_high_holding_latch;
        // only the core's own latch write moves it, never a push or a pop
        if (i_latch_wr) begin
            next_pc_high_holding_latch = i_latch_wdata;
        end
        next_status = `HRS_STAT_RESET;
        next_status[`HRS_STAT_FLAG_BIT] = (next_state == HRS_ST_AVAILABLE);
        next_status[`HRS_STAT_GLINT_BIT] = next_glint_disable;
        next_status[`HRS_STAT_TO_BIT] = i_timeout_n;
        next_status[`HRS_STAT_PD_BIT] = i_power_down_n;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            glint_disable <= `HRS_GLINT_RESET;
            pc_high_holding_latch <= `HRS_LATCH_RESET;
            status <= `HRS_STAT_RESET;
        end else begin
            glint_disable <= next_glint_disable;
            pc_high_holding_latch <= next_pc_high_holding_latch;
            status <= next_status;
        end
    end

    // status shows one cycle late for the power bits; the reset image has them clear
    assign o_cpu_status_register = status;
    assign o_global_int_disable = glint_disable;
    assign o_pc_high_holding_latch = pc_high_holding_latch;

endmodule

// [common/hrs_map.svh]
// constants for the hardware return stack: pointer values, status bit positions, reset values
`ifndef HRS_MAP_SVH
`define HRS_MAP_SVH

`define HRS_PTR_RESET 4'h0
`define HRS_PTR_TOP 4'hf
`define HRS_PC_RESET 16'h0000
`define HRS_LATCH_RESET 8'h00
`define HRS_STAT_ADDR 8'h06
`define HRS_STAT_FLAG_BIT 5
`define HRS_STAT_GLINT_BIT 4
`define HRS_STAT_TO_BIT 3
`define HRS_STAT_PD_BIT 2
`define HRS_GLINT_RESET 1'b1
`define HRS_STAT_RESET 8'h00

`endif

// [common/hrs_pkg.sv]
// types shared by the hardware return stack and its storage
package hrs_pkg;

    // what the sequencer is doing this cycle, as seen by the stack
    typedef enum logic [2:0] {
        HRS_OP_NONE,
        HRS_OP_CALL,
        HRS_OP_INT_ACK,
        HRS_OP_RETURN,
        HRS_OP_RETURN_WITH_LITERAL,
        HRS_OP_RETURN_FROM_INTERRUPT
    } hrs_op_type;

    // one request from the sequencer: the operation and the pc to save
    typedef struct packed {
        hrs_op_type op;
        logic [15:0] pc;
    } hrs_req_type;

    // answer to a pop: pc to load into the full program counter
    typedef struct packed {
        logic valid;
        logic [15:0] pc;
    } hrs_resp_type;

    // data bus write toward the unbanked status register
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hrs_dbus_type;

    typedef enum logic [1:0] {
        HRS_ST_AVAILABLE,
        HRS_ST_FULL,
        HRS_ST_LOCKED
    } hrs_state_type;

endpackage

// [rtl/hrs_stack_mem.sv]
// storage array of the return stack, one write port and one combinational read port
`timescale 1ns/1ps
module hrs_stack_mem
    import hrs_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int WIDTH = 16,
    parameter int AW = 4
) (
    input wire logic i_clk,
    input wire logic i_wr,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [WIDTH-1:0] o_rdata
);

    // no reset on the array: entries are only meaningful after a push
    logic [WIDTH-1:0] entry [DEPTH];

    always_ff @(posedge i_clk) begin
        if (i_wr) begin
            entry[i_waddr] <= i_wdata;
        end
    end

    assign o_rdata = entry[i_raddr];

endmodule

// [testbench/hrs_seq_model.sv]
// sequencer stand-in that forms stack requests
`timescale 1ns/1ps
module hrs_seq_model
    import hrs_pkg::*;
(
    input wire hrs_op_type i_op,
    input wire logic [15:0] i_pc,
    output hrs_req_type o_req
);
    // only none, call, interrupt and return codes exist, so no bare push or pop can be asked
    assign o_req = '{op: i_op, pc: i_pc};
endmodule

// [testbench/hrs_return_stack_props.sv]
// port assertions of the return stack
`timescale 1ns/1ps
module hrs_return_stack_props
    import hrs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire hrs_req_type i_req,
    input wire hrs_dbus_type i_dbus,
    input wire logic i_latch_wr,
    input wire logic i_timeout_n,
    input wire logic i_power_down_n,
    input wire hrs_resp_type o_pop,
    input wire logic o_stack_space_flag,
    input wire logic [7:0] o_cpu_status_register,
    input wire logic [7:0] o_pc_high_holding_latch
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    wire logic psh = i_req.op inside {HRS_OP_CALL, HRS_OP_INT_ACK};
    wire logic pop = i_req.op inside {HRS_OP_RETURN, HRS_OP_RETURN_WITH_LITERAL, HRS_OP_RETURN_FROM_INTERRUPT};
    wire logic swr = i_dbus.wr && i_dbus.addr == 8'h06 && i_req.op == HRS_OP_NONE;
    logic [3:0] ptr;
    logic lk;
    ////////////////////////////////////////
    // shadow pointer; the lock is set by any push out of fh
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ptr <= 4'h0;
            lk <= 1'b0;
        end else begin
            ptr <= ptr + (psh ? 4'h1 : (pop ? 4'hf : 4'h0));
            lk <= lk | (psh & (ptr == 4'hf));
        end
    end
    sequence s_pop;
        pop;
    endsequence
    sequence s_settled;
        !$past(i_sys_rst);
    endsequence
    ////////////////////////////////////////
    a_pop_answer: assert property (s_pop |=> o_pop.valid)
        else $error("pop not answered");
    a_no_extra: assert property (!pop |=> !o_pop.valid)
        else $error("answer without pop");
    a_pc_stands: assert property (!pop |=> $stable(o_pop.pc))
        else $error("popped pc moved");
    a_latch_kept: assert property (!i_latch_wr |=> $stable(o_pc_high_holding_latch))
        else $error("latch moved");
    a_flag_track: assert property (s_settled |->
        o_stack_space_flag == !(lk || ptr == 4'hf))
        else $error("flag wrong");
    a_status_flag: assert property (s_settled |-> o_cpu_status_register[5] == o_stack_space_flag)
        else $error("status bit5 wrong");
    a_power_bits: assert property (s_settled |->
        o_cpu_status_register[3:2] == {$past(i_timeout_n), $past(i_power_down_n)})
        else $error("power bits wrong");
    a_write_noflag: assert property (swr |=> $stable(o_stack_space_flag))
        else $error("write moved flag");
endmodule
bind hrs_return_stack hrs_return_stack_props i_props (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(i_req),
    .i_dbus(i_dbus), .i_latch_wr(i_latch_wr), .i_timeout_n(i_timeout_n), .i_power_down_n(i_power_down_n),
    .o_pop(o_pop), .o_stack_space_flag(o_stack_space_flag), .o_cpu_status_register(o_cpu_status_register),
    .o_pc_high_holding_latch(o_pc_high_holding_latch));

// [testbench/hrs_return_stack_bench.sv]
// testbench of the return stack
`timescale 1ns/1ps
module hrs_return_stack_bench
    import hrs_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, lwr = 1'b0, to_n = 1'b1, pd_n = 1'b1, flag, gid;
    logic [7:0] lwd = 8'h00, stat, latch;
    logic [15:0] pc = 16'h0000;
    hrs_op_type op = HRS_OP_NONE;
    hrs_dbus_type dbus = '0;
    hrs_req_type req;
    hrs_resp_type pop;
    int fail_count = 0, n_tests = 0, cyc = 0;
    initial forever #5 clk = ~clk;
    hrs_seq_model i_hrs_seq_model (.i_op(op), .i_pc(pc), .o_req(req));
    hrs_return_stack i_hrs_return_stack (.i_clk(clk), .i_sys_rst(rst), .i_req(req), .i_dbus(dbus),
        .i_latch_wr(lwr), .i_latch_wdata(lwd), .i_timeout_n(to_n), .i_power_down_n(pd_n), .o_pop(pop),
        .o_stack_space_flag(flag), .o_cpu_status_register(stat), .o_global_int_disable(gid),
        .o_pc_high_holding_latch(latch));
    ////////////////////////////////////////
    task give_verdict;
        $display("mismatches %0d, checks %0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // the request set here is taken at the following edge
    task drv(input hrs_op_type o, input logic [15:0] p);
        @(posedge clk);
        op <= o;
        pc <= p;
    endtask
    task do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
    endtask
    ////////////////////////////////////////
    task t_lifo;
        drv(HRS_OP_CALL, 16'h1111);
        lwr <= 1'b1;
        lwd <= 8'h5a;
        drv(HRS_OP_INT_ACK, 16'h2222);
        lwr <= 1'b0;
        drv(HRS_OP_CALL, 16'h3333);
        drv(HRS_OP_RETURN, 16'h0000);
        drv(HRS_OP_RETURN_WITH_LITERAL, 16'h0000);
        #1 chk(pop.pc, 16'h3333);
        chk({15'h0, pop.valid}, 16'h0001);
        drv(HRS_OP_RETURN_FROM_INTERRUPT, 16'h0000);
        #1 chk(pop.pc, 16'h2222);
        drv(HRS_OP_NONE, 16'h0000);
        dbus <= '{1'b1, 8'h06, 8'h00};
        to_n <= 1'b0;
        #1 chk(pop.pc, 16'h1111);
        drv(HRS_OP_NONE, 16'h0000);
        dbus <= '0;
        #1 chk({8'h00, stat}, 16'h0024);
        chk({15'h0, gid}, 16'h0000);
        chk({15'h0, pop.valid}, 16'h0000);
        chk({8'h00, latch}, 16'h005a);
    endtask
    // seventeen pushes wrap the pointer; pops then walk back over the overwritten slot
    task t_wrap;
        for (int k = 0; k < 17; k++) begin
            drv(HRS_OP_CALL, 16'h1000 + k[15:0]);
            #1 if (k == 15) chk({15'h0, flag}, 16'h0000);
        end
        for (int k = 16; k > 0; k--) begin
            drv(HRS_OP_RETURN, 16'h0000);
            #1 if (k < 16) chk(pop.pc, 16'h1001 + k[15:0]);
        end
        drv(HRS_OP_NONE, 16'h0000);
        #1 chk(pop.pc, 16'h1001);
        chk({15'h0, flag}, 16'h0000);
    endtask
    task t_early;
        drv(HRS_OP_RETURN, 16'h0000);
        drv(HRS_OP_NONE, 16'h0000);
        #1 chk({15'h0, flag}, 16'h0000);
        drv(HRS_OP_CALL, 16'h4444);
        drv(HRS_OP_RETURN, 16'h0000);
        drv(HRS_OP_RETURN, 16'h0000);
        #1 chk(pop.pc, 16'h4444);
        drv(HRS_OP_NONE, 16'h0000);
        #1 chk({15'h0, flag}, 16'h0000);
    endtask
    ////////////////////////////////////////
    // a hang ends the run well past the roughly eighty cycles the scenarios need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fail_count++;
            give_verdict();
        end
    end
    initial begin
        do_reset();
        #1 chk({15'h0, flag}, 16'h0001);
        t_lifo();
        do_reset();
        #1 chk({8'h00, latch}, 16'h0000);
        t_wrap();
        do_reset();
        #1 chk({15'h0, flag}, 16'h0001);
        t_early();
        give_verdict();
    end
endmodule
